// file: rsm_defines.svh
// Constants for the resolver setup and status map: word offsets, bit positions,
// range limits, reset values and timing counts. Assumes a 40 MHz system clock.
`ifndef RSM_DEFINES_SVH
`define RSM_DEFINES_SVH

// Clock rate in kHz, so a time in ms times this gives cycles
`define RSM_CLK_KHZ        40000
`define RSM_VEL_FAST_MS    32
`define RSM_VEL_SLOW_MS    125
`define RSM_HB_MS          500
`define RSM_VEL_FAST_CYC   (`RSM_VEL_FAST_MS * `RSM_CLK_KHZ)
`define RSM_VEL_SLOW_CYC   (`RSM_VEL_SLOW_MS * `RSM_CLK_KHZ)
`define RSM_HB_CYC         (`RSM_HB_MS * `RSM_CLK_KHZ)

// Input word offsets
`define RSM_W_MODULE       0
`define RSM_W_CH1_STAT     1
`define RSM_W_CH1_POS      2
`define RSM_W_CH1_VEL      3
`define RSM_W_RSVD4        4
`define RSM_W_CH2_STAT     5
`define RSM_W_CH2_POS      6
`define RSM_W_CH2_VEL      7
`define RSM_W_RSVD8        8
`define RSM_W_RSVD9        9
`define RSM_W_STRIDE       4

// Command word bits
`define RSM_CMD_XMIT       15
`define RSM_CMD_RST_ERR    14
`define RSM_CMD_PERSIST    13
`define RSM_CMD_PROG_B     5
`define RSM_CMD_PROG_A     4
`define RSM_CMD_PRESET_B   1
`define RSM_CMD_PRESET_A   0
`define RSM_CMD_RSVD_MASK  16'h1fcc

// Setup word: per channel nibble, channel b at bit 8
`define RSM_SET_SENSE      0
`define RSM_SET_HOLD       1
`define RSM_SET_OFF        2
`define RSM_SET_FAST       3
`define RSM_SET_RSVD_MASK  16'hf0f0

// Module status bits
`define RSM_MS_ACK         15
`define RSM_MS_HB          14
`define RSM_MS_DUAL        10
`define RSM_MS_SINGLE      9
`define RSM_MS_FREQ_ERR    3
`define RSM_MS_VOLT_ERR    2
`define RSM_MS_HW_FLT      1
`define RSM_MS_CMD_ERR     0

// Channel status bits
`define RSM_CS_DC_IN       11
`define RSM_CS_STILL       9
`define RSM_CS_OFF         8
`define RSM_CS_RATIO_ERR   4
`define RSM_CS_PRESET_ERR  3
`define RSM_CS_FSC_ERR     2
`define RSM_CS_SETUP_ERR   1
`define RSM_CS_FAULT       0

// Parameter ranges
`define RSM_FSC_MIN        16'd2
`define RSM_FSC_MAX        16'd8192
`define RSM_RATIO_MIN      16'd10
`define RSM_RATIO_MAX      16'd300
`define RSM_VOLT_MIN       16'd800
`define RSM_VOLT_MAX       16'd12000
`define RSM_FREQ_MIN       16'd400
`define RSM_FREQ_MAX       16'd10000

// Reset values of channel parameters
`define RSM_FSC_RST        16'd8192
`define RSM_PRESET_RST     16'd0
`define RSM_RATIO_RST      16'd95

`endif

// file: rsm_host_model.sv
// Host controller model: drives the ten output words and runs the transmit handshake.
// Assumes ack is module status bit 15 and that every call starts at a falling edge.
`timescale 1ns/100ps
module rsm_host_model (
	input  wire logic             sys_clk, // System clock
	input  wire logic             ack,     // Module acknowledge
	output      logic [15:0]      cmd_w,   // Command word
	output      logic [15:0]      set_w,   // Setup word
	output      logic [7:0][15:0] par_w    // Parameter words 2 to 9
);
	int n;
	// Idle words at time zero
	initial begin
		cmd_w = 16'h0000;
		set_w = 16'h0000;
		par_w = '0;
	end
	// Raise transmit and hold every word until ack is sampled high
	task automatic raise(input logic [15:0] c, input logic [15:0] s, input logic [7:0][15:0] p);
		cmd_w = c | 16'h8000;
		set_w = s;
		par_w = p;
		n = 0;
		while (ack !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	// Flags are only trusted before this drop; one idle cycle keeps blocks apart
	task automatic drop();
		cmd_w[15] = 1'b0;
		n = 0;
		while (ack !== 1'b0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
	endtask
endmodule

// file: rsm_map.sv
// Resolver setup decode and status word builder, two channels, single turn.
// Assumes the ten output words arrive on sys_clk from network logic; DC inputs are pins.
// Functional notes
// - Setup bit 11/3 picks 32 ms velocity refresh, else 125 ms; position unaffected.
// - Disable bit 10/2 turns channel off: indicator off, zero position and velocity.
// - Fault-hold bit 9/1 clear: fault self clears; set: fault held until cleared.
// - Held fault clears only on a block carrying error-reset command bit 14.
// - Sense bit 8/0: zero counts up clockwise, one counts up counter-clockwise.
// - Setup bits apply only when program bit 5 or 4 of that channel is set.
// - Ten input words: status, position, velocity per channel; words 4, 8, 9 zero.
// - Acknowledge bit 15 set on transmit, held until host drops transmit.
// - Heartbeat bit 14 toggles every 500 ms.
// - Status bit 10 flags multi-turn mode, bit 9 single-turn mode.
// - Bit 3 flags frequency outside 400..10000; bit 2 voltage outside 800..12000.
// - Bit 1 flags hardware fault, held until power-up restart.
// - Command error on reserved bits, preset during fault, or preset with setup.
// - Channel bit 11 shows DC input; its rising edge loads the preset position.
// - Channel bit 9 set when velocity is zero and no fault; 1 RPM resolution.
// - Channel bit 8 set while channel disabled.
// - Channel bit 4 flags ratio value outside 10..300.
// - Channel bit 3 flags preset outside zero to counts per turn minus one.
// - Channel bit 2 flags counts per turn outside 2..8192.
// - Channel bit 1 flags reserved setup bits 4..7 or 12..15 written as one.
// - Channel bit 0 shows transducer fault state.
// - Invalid parameter while leaving multi-turn keeps multi-turn and flags channel.
// - Block taken only on rising transmit edge; host holds transmit until acknowledged.
// - Error-reset clears all programming errors and clearable held faults.
// - Channel program bit enables its setup nibble together with its parameter words.
`timescale 1ns/100ps
`include "rsm_defines.svh"

module rsm_map #(
	parameter int VEL_FAST_CYC = `RSM_VEL_FAST_CYC, // Fast velocity refresh cycles
	parameter int VEL_SLOW_CYC = `RSM_VEL_SLOW_CYC, // Slow velocity refresh cycles
	parameter int HB_CYC       = `RSM_HB_CYC        // Heartbeat half period cycles
) (
	input  wire logic                   sys_clk,          // 40 MHz clock
	input  wire logic                   rst_b,            // Async reset, low
	input  wire rsm_pkg::rsm_word_t     command_word,     // Output word 0
	input  wire rsm_pkg::rsm_word_t     setup_word,       // Output word 1
	input  wire rsm_pkg::rsm_word_t     ch_a_fsc_word,    // Output word 2
	input  wire rsm_pkg::rsm_word_t     ch_a_preset_word, // Output word 3
	input  wire rsm_pkg::rsm_word_t     ch_a_ratio_word,  // Output word 4
	input  wire rsm_pkg::rsm_word_t     ch_b_fsc_word,    // Output word 5
	input  wire rsm_pkg::rsm_word_t     ch_b_preset_word, // Output word 6
	input  wire rsm_pkg::rsm_word_t     ch_b_ratio_word,  // Output word 7
	input  wire rsm_pkg::rsm_word_t     ref_level_word,   // Output word 8
	input  wire rsm_pkg::rsm_word_t     ref_freq_word,    // Output word 9
	input  wire logic [1:0][15:0]       raw_position,     // Converter angle, 0..fsc-1
	input  wire logic [1:0][15:0]       raw_velocity,     // Converter speed in RPM
	input  wire logic [1:0]             signal_valid,     // Resolver signals good
	input  wire logic [1:0]             dc_input_pin,     // DC input pins, async
	input  wire logic                   hw_fault,         // Internal hardware fault
	input  wire logic                   multi_turn_set,   // Multi-turn setup taken, pulse
	output      logic [9:0][15:0]       input_word,       // Ten words to the host
	output      logic [1:0]             channel_led_on    // Channel indicators
);
	import rsm_pkg::*;

	rsm_state_s s_reg;
	rsm_state_s s_next;

	// Parameter words gathered per channel
	logic [1:0][15:0] fsc_in;
	logic [1:0][15:0] preset_in;
	logic [1:0][15:0] ratio_in;
	logic [1:0][15:0] dir_pos;
	logic [1:0][15:0] pos_now;

	assign fsc_in    = {ch_b_fsc_word, ch_a_fsc_word};
	assign preset_in = {ch_b_preset_word, ch_a_preset_word};
	assign ratio_in  = {ch_b_ratio_word, ch_a_ratio_word};

	// Directed and offset position per channel; modular add avoids a divider
	always_comb begin
		logic [16:0] sum;
		sum = 17'h0;
		for (int i = 0; i < 2; i++) begin
			if (s_reg.ch[i].sense && raw_position[i] != 16'h0) begin
				dir_pos[i] = s_reg.ch[i].fsc - raw_position[i];
			end else begin
				dir_pos[i] = raw_position[i];
			end
			sum = {1'b0, dir_pos[i]} + {1'b0, s_reg.ch[i].offset};
			if (sum >= {1'b0, s_reg.ch[i].fsc}) begin
				sum = sum - {1'b0, s_reg.ch[i].fsc};
			end
			pos_now[i] = sum[15:0];
		end
	end

	// Next state: handshake, block decode, faults, timers and word build
	always_comb begin
		logic        rise;
		logic        clr;
		logic        any_prog;
		logic        cmd_bad;
		logic        blk_err;
		logic [1:0]  prog;
		logic [1:0]  preset_req;
		logic [1:0]  dc_rise;
		logic [3:0]  nib;
		logic        e_ratio;
		logic        e_preset;
		logic        e_fsc;
		logic        e_setup;
		logic        e_freq;
		logic        e_volt;
		logic [15:0] load;
		logic [31:0] period;
		logic [15:0] ms;
		logic [15:0] cs;
		rise = 1'b0;
		clr = 1'b0;
		any_prog = 1'b0;
		cmd_bad = 1'b0;
		blk_err = 1'b0;
		prog = 2'h0;
		preset_req = 2'h0;
		dc_rise = 2'h0;
		nib = 4'h0;
		e_ratio = 1'b0;
		e_preset = 1'b0;
		e_fsc = 1'b0;
		e_setup = 1'b0;
		e_freq = 1'b0;
		e_volt = 1'b0;
		load = 16'h0;
		period = 32'h0;
		ms = 16'h0;
		cs = 16'h0;
		s_next = s_reg;

		// Block taken only on a rising transmit edge
		rise = command_word[`RSM_CMD_XMIT] && !s_reg.xmit_prev;
		s_next.xmit_prev = command_word[`RSM_CMD_XMIT];
		// Acknowledge holds while transmit stays high
		s_next.ack = command_word[`RSM_CMD_XMIT] && (s_reg.ack || rise);

		clr = rise && command_word[`RSM_CMD_RST_ERR];
		prog = {command_word[`RSM_CMD_PROG_B], command_word[`RSM_CMD_PROG_A]};
		preset_req = {command_word[`RSM_CMD_PRESET_B], command_word[`RSM_CMD_PRESET_A]};
		any_prog = |prog;

		// Command error: reserved bits, preset in fault, preset with setup
		cmd_bad = |(command_word & `RSM_CMD_RSVD_MASK)
			|| (any_prog && |(setup_word & `RSM_SET_RSVD_MASK));
		for (int i = 0; i < 2; i++) begin
			if (preset_req[i] && (s_reg.ch[i].fault || prog[i])) begin
				cmd_bad = 1'b1;
			end
		end

		// Excitation range checks apply when either channel programs
		e_freq = any_prog && (ref_freq_word < `RSM_FREQ_MIN || ref_freq_word > `RSM_FREQ_MAX);
		e_volt = any_prog && (ref_level_word < `RSM_VOLT_MIN || ref_level_word > `RSM_VOLT_MAX);
		blk_err = cmd_bad || e_freq || e_volt;

		// Error flags: clear first, so an error in the same block still sets
		if (clr) begin
			s_next.err_cmd = 1'b0;
			s_next.err_freq = 1'b0;
			s_next.err_volt = 1'b0;
		end
		if (rise) begin
			s_next.err_cmd = s_next.err_cmd || cmd_bad;
			s_next.err_freq = s_next.err_freq || e_freq;
			s_next.err_volt = s_next.err_volt || e_volt;
		end
		// Only a power-up restart clears the hardware fault
		s_next.hw_flt = s_reg.hw_flt || hw_fault;

		for (int i = 0; i < 2; i++) begin
			nib = setup_word[i*`RSM_W_STRIDE*2 +: 4];
			// Any reserved setup bit flags every channel being programmed, not only its own nibble
			e_setup = prog[i] && |(setup_word & `RSM_SET_RSVD_MASK);
			e_fsc = prog[i] && (fsc_in[i] < `RSM_FSC_MIN || fsc_in[i] > `RSM_FSC_MAX);
			e_preset = prog[i] && (preset_in[i] >= fsc_in[i]);
			e_ratio = prog[i] && (ratio_in[i] < `RSM_RATIO_MIN || ratio_in[i] > `RSM_RATIO_MAX);
			blk_err = blk_err || e_setup || e_fsc || e_preset || e_ratio;

			// DC input: two flops, then edge detect on the second
			s_next.ch[i].dc_s1 = dc_input_pin[i];
			s_next.ch[i].dc_s2 = s_reg.ch[i].dc_s1;
			s_next.ch[i].dc_prev = s_reg.ch[i].dc_s2;
			dc_rise[i] = s_reg.ch[i].dc_s2 && !s_reg.ch[i].dc_prev;

			if (clr) begin
				s_next.ch[i].err_ratio = 1'b0;
				s_next.ch[i].err_preset = 1'b0;
				s_next.ch[i].err_fsc = 1'b0;
				s_next.ch[i].err_setup = 1'b0;
			end
			if (rise) begin
				s_next.ch[i].err_ratio = s_next.ch[i].err_ratio || e_ratio;
				s_next.ch[i].err_preset = s_next.ch[i].err_preset || e_preset;
				s_next.ch[i].err_fsc = s_next.ch[i].err_fsc || e_fsc;
				s_next.ch[i].err_setup = s_next.ch[i].err_setup || e_setup;
			end

			// Accept channel setup only if its own words are valid and no command error
			if (rise && prog[i] && !cmd_bad && !(e_setup || e_fsc || e_preset || e_ratio)) begin
				s_next.ch[i].sense = nib[`RSM_SET_SENSE];
				s_next.ch[i].hold = nib[`RSM_SET_HOLD];
				s_next.ch[i].off = nib[`RSM_SET_OFF];
				s_next.ch[i].fast = nib[`RSM_SET_FAST];
				s_next.ch[i].fsc = fsc_in[i];
				s_next.ch[i].preset = preset_in[i];
				s_next.ch[i].ratio = ratio_in[i];
			end

			// Preset by command or DC edge; offset kept only in this register
			if ((rise && preset_req[i] && !cmd_bad) || dc_rise[i]) begin
				load = s_reg.ch[i].preset - dir_pos[i];
				if (s_reg.ch[i].preset < dir_pos[i]) begin
					load = load + s_reg.ch[i].fsc;
				end
				s_next.ch[i].offset = load;
			end

			// Fault: a loss of signal sets, which wins over the clear
			s_next.ch[i].fault = !signal_valid[i]
				|| (s_reg.ch[i].fault && s_reg.ch[i].hold && !clr);

			// Velocity refresh timer; only the velocity word waits on it
			period = s_reg.ch[i].fast ? 32'(VEL_FAST_CYC) : 32'(VEL_SLOW_CYC);
			if (s_reg.ch[i].vel_cnt >= period - 32'd1) begin
				s_next.ch[i].vel_cnt = 32'h0;
				s_next.ch[i].vel = raw_velocity[i];
			end else begin
				s_next.ch[i].vel_cnt = s_reg.ch[i].vel_cnt + 32'd1;
			end
		end

		// Mode: leaving multi-turn needs a clean block
		if (multi_turn_set) begin
			s_next.multi = 1'b1;
		end else if (rise && any_prog && !blk_err) begin
			s_next.multi = 1'b0;
		end

		// Heartbeat divider
		if (s_reg.hb_cnt >= 32'(HB_CYC) - 32'd1) begin
			s_next.hb_cnt = 32'h0;
			s_next.hb = !s_reg.hb;
		end else begin
			s_next.hb_cnt = s_reg.hb_cnt + 32'd1;
		end

		// Module status word
		ms = 16'h0;
		ms[`RSM_MS_ACK] = s_next.ack;
		ms[`RSM_MS_HB] = s_next.hb;
		ms[`RSM_MS_DUAL] = s_next.multi;
		ms[`RSM_MS_SINGLE] = !s_next.multi;
		ms[`RSM_MS_FREQ_ERR] = s_next.err_freq;
		ms[`RSM_MS_VOLT_ERR] = s_next.err_volt;
		ms[`RSM_MS_HW_FLT] = s_next.hw_flt;
		ms[`RSM_MS_CMD_ERR] = s_next.err_cmd;
		s_next.word = '0;
		s_next.word[`RSM_W_MODULE] = ms;

		// Channel words; an off channel reports zero data
		for (int i = 0; i < 2; i++) begin
			cs = 16'h0;
			cs[`RSM_CS_DC_IN] = s_next.ch[i].dc_prev;
			cs[`RSM_CS_STILL] = (s_next.ch[i].vel == 16'h0) && !s_next.ch[i].fault;
			cs[`RSM_CS_OFF] = s_next.ch[i].off;
			cs[`RSM_CS_RATIO_ERR] = s_next.ch[i].err_ratio;
			cs[`RSM_CS_PRESET_ERR] = s_next.ch[i].err_preset;
			cs[`RSM_CS_FSC_ERR] = s_next.ch[i].err_fsc;
			cs[`RSM_CS_SETUP_ERR] = s_next.ch[i].err_setup;
			cs[`RSM_CS_FAULT] = s_next.ch[i].fault;
			s_next.word[`RSM_W_CH1_STAT + i*`RSM_W_STRIDE] = cs;
			if (!s_next.ch[i].off) begin
				s_next.word[`RSM_W_CH1_POS + i*`RSM_W_STRIDE] = pos_now[i];
				s_next.word[`RSM_W_CH1_VEL + i*`RSM_W_STRIDE] = s_next.ch[i].vel;
			end else begin
				s_next.word[`RSM_W_CH1_POS + i*`RSM_W_STRIDE] = 16'h0;
				s_next.word[`RSM_W_CH1_VEL + i*`RSM_W_STRIDE] = 16'h0;
			end
		end
	end

	// State register; reset leaves channels on with default parameters
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
			for (int i = 0; i < 2; i++) begin
				s_reg.ch[i].fsc <= `RSM_FSC_RST;
				s_reg.ch[i].preset <= `RSM_PRESET_RST;
				s_reg.ch[i].ratio <= `RSM_RATIO_RST;
			end
			s_reg.word[`RSM_W_MODULE][`RSM_MS_SINGLE] <= 1'b1; // Words agree with the reset mode
		end else begin
			s_reg <= s_next;
		end
	end

	assign input_word = s_reg.word;
	assign channel_led_on = {!s_reg.ch[1].off, !s_reg.ch[0].off};

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence xmit_edge_s;
		!command_word[`RSM_CMD_XMIT] ##1 command_word[`RSM_CMD_XMIT];
	endsequence

	sequence ack_shown_s;
		##1 input_word[`RSM_W_MODULE][`RSM_MS_ACK];
	endsequence

	// A block that asks for nothing but the error reset
	sequence reset_block_s;
		xmit_edge_s ##0 command_word[14:0] == 15'h4000;
	endsequence

	// Ack is registered at the take edge, so it shows on the very next edge
	ack_after_xmit_a: assert property (xmit_edge_s |-> ack_shown_s)
		else $error("acknowledge not shown one cycle after transmit edge");

	// A low transmit clears ack at once; a new block may rise just one cycle later
	ack_drop_a: assert property (!command_word[`RSM_CMD_XMIT] |=> !input_word[`RSM_W_MODULE][`RSM_MS_ACK])
		else $error("acknowledge still set after transmit dropped");

	reserved_zero_a: assert property (input_word[`RSM_W_RSVD4] == 16'h0 && input_word[`RSM_W_RSVD8] == 16'h0
		&& input_word[`RSM_W_RSVD9] == 16'h0)
		else $error("reserved input word not zero");

	// The reset value of the single bit keeps these opposite from the first edge
	mode_bits_a: assert property (input_word[`RSM_W_MODULE][`RSM_MS_DUAL] != input_word[`RSM_W_MODULE][`RSM_MS_SINGLE])
		else $error("mode bits not opposite");

	hw_sticky_a: assert property ($rose(input_word[`RSM_W_MODULE][`RSM_MS_HW_FLT]) |=>
		input_word[`RSM_W_MODULE][`RSM_MS_HW_FLT] [*8])
		else $error("hardware fault flag dropped");

	off_zero_a: assert property (input_word[`RSM_W_CH2_STAT][`RSM_CS_OFF] |->
		input_word[`RSM_W_CH2_POS] == 16'h0 && input_word[`RSM_W_CH2_VEL] == 16'h0 && !channel_led_on[1])
		else $error("disabled channel reports data");

	still_fault_a: assert property (input_word[`RSM_W_CH1_STAT][`RSM_CS_FAULT] |-> !input_word[`RSM_W_CH1_STAT][`RSM_CS_STILL])
		else $error("standstill shown during fault");

	moving_still_a: assert property (input_word[`RSM_W_CH1_VEL] != 16'h0 |->
		!input_word[`RSM_W_CH1_STAT][`RSM_CS_STILL])
		else $error("standstill shown while velocity is not zero");

	// Fault is registered in the cycle of the loss; a self-clearing fault may go the next cycle
	fault_follow_a: assert property (!signal_valid[0] |=> input_word[`RSM_W_CH1_STAT][`RSM_CS_FAULT])
		else $error("fault not shown after signal loss");

	// The status bit comes from the edge-detect stage, one edge behind the second flop
	dc_bit_follow_a: assert property ($rose(s_reg.ch[0].dc_s2) |=>
		input_word[`RSM_W_CH1_STAT][`RSM_CS_DC_IN])
		else $error("DC input bit not shown after synchronised edge");

	hb_steady_a: assert property ($changed(s_reg.hb) |=> $stable(s_reg.hb) [*2])
		else $error("heartbeat toggles too fast");

	// The divider wraps at HB_CYC minus one, so its count never reaches the limit
	hb_bound_a: assert property (s_reg.hb_cnt < 32'(HB_CYC))
		else $error("heartbeat counter past its limit");

	err_clear_a: assert property (reset_block_s |=> !input_word[`RSM_W_MODULE][`RSM_MS_CMD_ERR]
		&& !input_word[`RSM_W_MODULE][`RSM_MS_FREQ_ERR] && !input_word[`RSM_W_MODULE][`RSM_MS_VOLT_ERR])
		else $error("programming error flags survive an error-reset block");

	// Only a taken block may clear the command error
	err_hold_a: assert property (input_word[`RSM_W_MODULE][`RSM_MS_CMD_ERR]
		&& !(command_word[`RSM_CMD_XMIT] && !s_reg.xmit_prev) |=> input_word[`RSM_W_MODULE][`RSM_MS_CMD_ERR])
		else $error("command error dropped without block");

endmodule

// file: rsm_pkg.sv
// Types for the resolver setup and status map.
// Assumes rsm_defines.svh provides the numeric constants.
package rsm_pkg;

	typedef logic [15:0] rsm_word_t;

	// Per channel state
	typedef struct packed {
		logic       fast;      // Short velocity refresh
		logic       off;       // Channel turned off
		logic       hold;      // Fault hold enable
		logic       sense;     // Rotation sense
		logic [15:0] fsc;      // Counts per turn
		logic [15:0] preset;   // Preset value
		logic [15:0] ratio;    // Ratio value
		logic [15:0] offset;   // Position offset
		logic [15:0] vel;      // Sampled velocity
		logic [31:0] vel_cnt;  // Refresh timer
		logic       fault;     // Transducer fault
		logic       dc_s1;     // DC input sync stage 1
		logic       dc_s2;     // DC input sync stage 2
		logic       dc_prev;   // For edge detect
		logic       err_ratio;
		logic       err_preset;
		logic       err_fsc;
		logic       err_setup;
	} rsm_chan_s;

	// Whole block state
	typedef struct packed {
		rsm_chan_s [1:0]        ch;
		logic                   ack;
		logic                   xmit_prev;
		logic                   hb;
		logic [31:0]            hb_cnt;
		logic                   multi;
		logic                   err_freq;
		logic                   err_volt;
		logic                   hw_flt;
		logic                   err_cmd;
		logic [9:0][15:0]       word;
	} rsm_state_s;

endpackage

// file: test_resolver_setup_status_map.sv
// Self-checking bench for the resolver setup and status map.
// Assumes the host model beside it; refresh and heartbeat counts are shortened.
`timescale 1ns/100ps
module test_resolver_setup_status_map;
	import rsm_pkg::*;
	localparam int VF = 8;
	localparam int VS = 20;
	localparam int HB = 16;
	localparam logic [7:0][15:0] GOOD = {16'h09c4, 16'h0cb2, 16'h005f, 16'h0000,
		16'h03e8, 16'h005f, 16'h0000, 16'h03e8};
	logic             sys_clk = 1'b0;
	logic             rst_b = 1'b0;
	logic [1:0][15:0] raw_pos = '0;
	logic [1:0][15:0] raw_vel = '0;
	logic [1:0]       sig_ok = 2'b11;
	logic [1:0]       dc_in = 2'b00;
	logic             hw_flt = 1'b0;
	logic             mt_set = 1'b0;
	logic             vel_run = 1'b0;
	rsm_word_t        cmd_w;
	rsm_word_t        set_w;
	logic [7:0][15:0] par_w;
	logic [9:0][15:0] iw;
	logic [1:0]       led;
	int               failures = 0;
	int               n_tests = 0;
	int               cyc_n = 0;
	// Case: cmd, setup, word index, status word, bit, flag expected, value
	logic [63:0] tab [15] = '{64'h0010_0000_0121_0001, 64'h0010_0000_0121_2001,
		64'h0010_0000_0120_2000, 64'h0020_0000_5541_0009, 64'h0020_0000_5541_012d,
		64'h0020_0000_5540_000a, 64'h0010_0000_1131_03e8, 64'h0010_0000_1130_03e7,
		64'h0010_0000_7031_018f, 64'h0020_0000_7031_2711, 64'h0010_0000_6021_031f,
		64'h0010_0000_6021_2ee1, 64'h0010_0010_2111_005f, 64'h0011_0000_0001_03e8,
		64'h0100_0000_0001_03e8};
	rsm_host_model host_u (.sys_clk(sys_clk), .ack(iw[0][15]), .cmd_w(cmd_w), .set_w(set_w), .par_w(par_w));
	rsm_map #(.VEL_FAST_CYC(VF), .VEL_SLOW_CYC(VS), .HB_CYC(HB)) dut_u (
		.sys_clk(sys_clk), .rst_b(rst_b), .command_word(cmd_w), .setup_word(set_w),
		.ch_a_fsc_word(par_w[0]), .ch_a_preset_word(par_w[1]), .ch_a_ratio_word(par_w[2]),
		.ch_b_fsc_word(par_w[3]), .ch_b_preset_word(par_w[4]), .ch_b_ratio_word(par_w[5]),
		.ref_level_word(par_w[6]), .ref_freq_word(par_w[7]), .raw_position(raw_pos),
		.raw_velocity(raw_vel), .signal_valid(sig_ok), .dc_input_pin(dc_in), .hw_fault(hw_flt),
		.multi_turn_set(mt_set), .input_word(iw), .channel_led_on(led));
	// Clock
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Speed ramp so every velocity refresh shows a new value; cycle ceiling
	always @(negedge sys_clk) begin
		if (vel_run)
			raw_vel[0] <= raw_vel[0] + 16'h0001;
	end
	always @(posedge sys_clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic blk(input rsm_word_t c, input rsm_word_t s, input logic [7:0][15:0] p);
		host_u.raise(c, s, p);
		host_u.drop();
	endtask
	task automatic t_layout();
		chk("mode", 16'h0200, iw[0] & 16'h0600);
		chk("w4", 16'h0000, iw[4]);
		chk("w8", 16'h0000, iw[8]);
		chk("w9", 16'h0000, iw[9]);
	endtask
	task automatic t_hb();
		logic [15:0] h;
		h = iw[0] & 16'h4000;
		cyc(HB);
		chk("heartbeat", h ^ 16'h4000, iw[0] & 16'h4000);
	endtask
	// Ack must stand for as long as the host holds transmit
	task automatic t_ack();
		host_u.raise(16'h0000, 16'h0000, GOOD);
		cyc(4);
		chk("ack held", 16'h8000, iw[0] & 16'h8000);
		host_u.drop();
		chk("ack clear", 16'h0000, iw[0] & 16'h8000);
	endtask
	// Each bad or boundary value, then an error-reset block clears the flag
	task automatic t_ranges();
		logic [63:0] t;
		logic [7:0][15:0] p;
		logic [15:0] m;
		for (int i = 0; i < 15; i++) begin
			t = tab[i];
			p = GOOD;
			p[t[31:28]] = t[15:0];
			m = 16'h0001 << t[23:20];
			host_u.raise(t[63:48], t[47:32], p);
			chk("flag", t[16] ? m : 16'h0000, iw[t[27:24]] & m);
			host_u.drop();
			host_u.raise(16'h4000, 16'h0000, GOOD);
			chk("flag reset", 16'h0000, iw[t[27:24]] & m);
			host_u.drop();
		end
	endtask
	task automatic t_sense();
		raw_pos[0] = 16'h0064;
		blk(16'h0010, 16'h0000, GOOD);
		chk("pos cw", 16'h0064, iw[2]);
		blk(16'h0000, 16'h0001, GOOD);
		chk("pos ignored", 16'h0064, iw[2]);
		blk(16'h0010, 16'h0001, GOOD);
		chk("pos ccw", 16'h0384, iw[2]);
		blk(16'h0010, 16'h0000, GOOD);
	endtask
	task automatic t_disable();
		raw_pos[1] = 16'h0023;
		raw_vel[1] = 16'h0011;
		blk(16'h0020, 16'h0400, GOOD);
		chk("b off", 16'h0100, iw[5] & 16'h0100);
		chk("b pos", 16'h0000, iw[6]);
		chk("b vel", 16'h0000, iw[7]);
		chk("b led", 16'h0001, {14'h0000, led});
		blk(16'h0020, 16'h0000, GOOD);
		chk("b pos on", 16'h0023, iw[6]);
	endtask
	// Measure one full refresh interval, then let the speed fall to zero
	task automatic t_vel(input rsm_word_t s, input int per);
		int k;
		logic [15:0] v;
		blk(16'h0010, s, GOOD);
		vel_run = 1'b1;
		for (int j = 0; j < 2; j++) begin
			v = iw[3];
			k = 0;
			while (iw[3] === v && k < 50) begin
				cyc(1);
				k++;
			end
		end
		chk("vel period", per[15:0], k[15:0]);
		chk("moving", 16'h0000, iw[1] & 16'h0200);
		vel_run = 1'b0;
		// Let the ramp see the stop first, so no late increment lands on the zero
		cyc(1);
		raw_vel[0] = 16'h0000;
		cyc(2 * per + 4);
		chk("still", 16'h0200, iw[1] & 16'h0200);
	endtask
	task automatic t_fault();
		sig_ok[0] = 1'b0;
		cyc(3);
		chk("fault", 16'h0001, iw[1] & 16'h0201);
		host_u.raise(16'h0001, 16'h0000, GOOD);
		chk("preset in fault", 16'h0001, iw[0] & 16'h0001);
		host_u.drop();
		sig_ok[0] = 1'b1;
		cyc(3);
		chk("self clear", 16'h0000, iw[1] & 16'h0001);
		blk(16'h4010, 16'h0002, GOOD);
		sig_ok[0] = 1'b0;
		cyc(3);
		sig_ok[0] = 1'b1;
		cyc(5);
		chk("held", 16'h0001, iw[1] & 16'h0001);
		host_u.raise(16'h4000, 16'h0000, GOOD);
		chk("cleared", 16'h0000, iw[1] & 16'h0001);
		host_u.drop();
	endtask
	task automatic t_dc();
		logic [7:0][15:0] p;
		p = GOOD;
		p[1] = 16'h0032;
		raw_pos[0] = 16'h012c;
		blk(16'h0010, 16'h0000, p);
		dc_in[0] = 1'b1;
		cyc(5);
		chk("dc bit", 16'h0800, iw[1] & 16'h0800);
		chk("preset pos", 16'h0032, iw[2]);
		raw_pos[0] = 16'h0136;
		cyc(2);
		chk("offset pos", 16'h003c, iw[2]);
		blk(16'h0001, 16'h0000, p);
		chk("cmd preset", 16'h0032, iw[2]);
		chk("preset no err", 16'h0000, iw[0] & 16'h0001);
		dc_in[0] = 1'b0;
	endtask
	// Hardware fault survives error reset; a bad block keeps multi-turn mode
	task automatic t_hw_mt();
		logic [7:0][15:0] p;
		p = GOOD;
		p[0] = 16'h0001;
		hw_flt = 1'b1;
		mt_set = 1'b1;
		cyc(1);
		hw_flt = 1'b0;
		mt_set = 1'b0;
		cyc(3);
		chk("multi", 16'h0400, iw[0] & 16'h0600);
		host_u.raise(16'h4010, 16'h0000, p);
		chk("stay multi", 16'h0400, iw[0] & 16'h0600);
		chk("ch flag", 16'h0004, iw[1] & 16'h0004);
		chk("hw flt", 16'h0002, iw[0] & 16'h0002);
		host_u.drop();
		blk(16'h4010, 16'h0000, GOOD);
		chk("single", 16'h0200, iw[0] & 16'h0600);
	endtask
	// Main sequence
	initial begin
		cyc(6);
		rst_b = 1'b1;
		cyc(2);
		t_layout();
		t_hb();
		t_ack();
		t_ranges();
		t_sense();
		t_disable();
		t_vel(16'h0008, VF);
		t_vel(16'h0000, VS);
		t_fault();
		t_dc();
		t_hw_mt();
		tally_and_finish();
	end
endmodule
